//--- src/wwd_pkg.sv
`default_nettype none
package wwd_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned PRESCALE_DIV  = 16384;
  localparam int unsigned RST_TIME_NS   = 30_000;
  localparam int unsigned RST_PULSE_CYC = (RST_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned PULSE_CNT_W   = 12;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] WIN_OFS  = 12'h004;
  localparam logic [11:0] STAT_OFS = 12'h008;

  // ----------------------------------------------------------------
  // Field positions and values
  // ----------------------------------------------------------------
  localparam int unsigned ACT_BIT     = 7;
  localparam int unsigned TOP_BIT     = 6;
  localparam int unsigned CAUSE_EXP   = 0;
  localparam int unsigned CAUSE_WIN   = 1;
  localparam int unsigned CAUSE_SW    = 2;
  localparam int unsigned CAUSE_HALT  = 3;
  localparam logic [6:0]  CNT_RST     = 7'h7F;
  localparam logic [6:0]  WIN_RST     = 7'h7F;
  localparam logic [6:0]  EXPIRE_CNT  = 7'h40;
  localparam logic [3:0]  STAT_RST    = 4'h0;

  // ----------------------------------------------------------------
  // Reset pulse states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    WWD_IDLE  = 2'b01,
    WWD_PULSE = 2'b10
  } wwd_state_e;

endpackage
`default_nettype wire

//--- src/wwd_prescaler.sv
`timescale 1ns/1ns
`default_nettype none
module wwd_prescaler #(
  parameter int unsigned DIV = 16384
) (
  input  wire logic pclk,
  input  wire logic presetn,
  output var  logic tick_q
);

  localparam int unsigned W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] div_q;

  // ----------------------------------------------------------------
  // Free-running divider, never cleared by software
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      div_q  <= (div_q == LAST) ? '0 : div_q + 1'b1;
      tick_q <= (div_q == LAST);
    end
  end

  property p_tick_single;
    @(posedge pclk) disable iff (!presetn)
    tick_q |=> !tick_q;
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("prescaler tick longer than one cycle");

endmodule // wwd_prescaler
`default_nettype wire

//--- src/wwd_top.sv
// Behaviour
// - Counter decrements once per 16384 clock prescaler period.
// - Active watchdog resets when counter rolls from 40h to 3Fh.
// - Watchdog reset holds reset pin low for 30 us.
// - Refresh of active watchdog while counter above window limit causes a reset.
// - Software option: inactive after reset, activation bit sticky until reset.
// - Hardware option: always active, activation bit ignored.
// - Counter runs even when watchdog is not active.
// - Writing activation set with top bit clear resets at once.
// - Active watchdog with halt-reset option and oscillator irq off resets on halt.
// - Low six counter bits give timeout of 1 to 64 prescaled steps.
// - Control writes never clear the prescaler.
// - Oscillator irq off plus halt-reset option: halt of active watchdog gives reset.
`timescale 1ns/1ns
`default_nettype none
module wwd_top #(
  parameter int unsigned PRESCALE = wwd_pkg::PRESCALE_DIV
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        hw_watchdog_opt,
  input  wire logic        halt_reset_option,
  input  wire logic        oscillator_irq_enable,
  input  wire logic        halt_req,
  output var  logic        rst_pin_n,
  output var  logic        reset_req,
  output var  logic        halt_grant
);

  localparam int PULSE_N = wwd_pkg::RST_PULSE_CYC;
  localparam logic [wwd_pkg::PULSE_CNT_W-1:0] PULSE_LAST =
    wwd_pkg::PULSE_CNT_W'(wwd_pkg::RST_PULSE_CYC - 1);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [6:0]                      cnt_q;
  logic [6:0]                      win_q;
  logic                            act_q;
  logic [3:0]                      stat_q;
  logic                            hw_opt_q;
  logic                            halt_opt_q;
  logic                            pready_q;
  logic [31:0]                     prdata_q;
  logic                            pslverr_q;
  logic                            rst_pin_n_q;
  logic                            reset_req_q;
  logic                            halt_grant_q;
  logic [wwd_pkg::PULSE_CNT_W-1:0] pcnt_q;
  wwd_pkg::wwd_state_e             state_q;
  logic                            tick;

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  wwd_prescaler #(
    .DIV (PRESCALE)
  ) u_prescaler (
    .pclk    (pclk),
    .presetn (presetn),
    .tick_q  (tick)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic       setup_acc;
  logic       done;
  logic       wr_ctrl;
  logic       wr_win;
  logic       wr_stat;
  logic       mapped;
  logic       active;
  logic [3:0] cause;

  // Access completes on the second access cycle
  assign setup_acc = psel & penable & ~pready_q;
  assign done      = psel & penable & pready_q;
  assign wr_ctrl   = done & pwrite & (paddr == wwd_pkg::CTRL_OFS);
  assign wr_win    = done & pwrite & (paddr == wwd_pkg::WIN_OFS);
  assign wr_stat   = done & pwrite & (paddr == wwd_pkg::STAT_OFS);
  assign mapped    = (paddr == wwd_pkg::CTRL_OFS) | (paddr == wwd_pkg::WIN_OFS) |
                     (paddr == wwd_pkg::STAT_OFS);

  // Effective activation
  assign active = hw_opt_q | act_q;

  // Reset causes in this cycle
  assign cause[wwd_pkg::CAUSE_EXP]  = active & tick & ~wr_ctrl & (cnt_q == wwd_pkg::EXPIRE_CNT);
  assign cause[wwd_pkg::CAUSE_WIN]  = wr_ctrl & active & (cnt_q > win_q);
  assign cause[wwd_pkg::CAUSE_SW]   = wr_ctrl & (active | pwdata[wwd_pkg::ACT_BIT]) &
                                      ~pwdata[wwd_pkg::TOP_BIT];
  assign cause[wwd_pkg::CAUSE_HALT] = halt_req & active & halt_opt_q & ~oscillator_irq_enable;

  // ----------------------------------------------------------------
  // Option straps, caught by the clock
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hw_opt_q   <= 1'b0;
      halt_opt_q <= 1'b0;
    end
    else
    begin
      hw_opt_q   <= hw_watchdog_opt;
      halt_opt_q <= halt_reset_option;
    end
  end

  // ----------------------------------------------------------------
  // APB handshake and read data
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q  <= setup_acc;
      pslverr_q <= setup_acc & ~mapped;
    end
  end

  // Read data captured in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000;
    end
    else if (setup_acc)
    begin
      unique case (paddr)
        wwd_pkg::CTRL_OFS: prdata_q <= {24'h00_0000, active, cnt_q};
        wwd_pkg::WIN_OFS:  prdata_q <= {25'h000_0000, win_q};
        wwd_pkg::STAT_OFS: prdata_q <= {28'h000_0000, stat_q};
        default:           prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Downcounter
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= wwd_pkg::CNT_RST;
    else if (wr_ctrl)
      cnt_q <= pwdata[6:0];
    else if (tick)
      cnt_q <= cnt_q - 7'h01;
  end

  // ----------------------------------------------------------------
  // Activation and window limit
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      act_q <= 1'b0;
    else if (wr_ctrl & pwdata[wwd_pkg::ACT_BIT])
      act_q <= 1'b1;
  end

  // Window limit register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      win_q <= wwd_pkg::WIN_RST;
    else if (wr_win)
      win_q <= pwdata[6:0];
  end

  // ----------------------------------------------------------------
  // Cause flags, write one to clear, set wins
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat_q <= wwd_pkg::STAT_RST;
    end
    else
    begin
      stat_q <= (stat_q & ~(wr_stat ? pwdata[3:0] : 4'h0)) | cause;
    end
  end

  // ----------------------------------------------------------------
  // Reset pulse sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q     <= wwd_pkg::WWD_IDLE;
      pcnt_q      <= '0;
      rst_pin_n_q <= 1'b1;
      reset_req_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        wwd_pkg::WWD_IDLE:
        begin
          if (|cause)
          begin
            state_q     <= wwd_pkg::WWD_PULSE;
            pcnt_q      <= '0;
            rst_pin_n_q <= 1'b0;
            reset_req_q <= 1'b1;
          end
        end
        wwd_pkg::WWD_PULSE:
        begin
          if (pcnt_q == PULSE_LAST)
          begin
            state_q     <= wwd_pkg::WWD_IDLE;
            rst_pin_n_q <= 1'b1;
            reset_req_q <= 1'b0;
          end
          else
          begin
            pcnt_q <= pcnt_q + 1'b1;
          end
        end
        default:
        begin
          state_q     <= wwd_pkg::WWD_IDLE;
          rst_pin_n_q <= 1'b1;
          reset_req_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Halt grant when no reset replaces the halt
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      halt_grant_q <= 1'b0;
    else
      halt_grant_q <= halt_req & ~cause[wwd_pkg::CAUSE_HALT];
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign rst_pin_n  = rst_pin_n_q;
  assign reset_req  = reset_req_q;
  assign halt_grant = halt_grant_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [wwd_pkg::PULSE_CNT_W-1:0] low_cnt_q;

  // Cycles the reset pin has been low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      low_cnt_q <= '0;
    end
    else
    begin
      low_cnt_q <= rst_pin_n_q ? '0 : low_cnt_q + 1'b1;
    end
  end

  property p_tick_dec;
    @(posedge pclk) disable iff (!presetn)
    (tick & ~wr_ctrl) |=> (cnt_q == $past(cnt_q) - 7'h01);
  endproperty
  a_tick_dec: assert property (p_tick_dec) else $error("counter missed a decrement");

  property p_expiry;
    @(posedge pclk) disable iff (!presetn)
    (active & tick & ~wr_ctrl & (cnt_q == 7'h40) & (state_q == wwd_pkg::WWD_IDLE))
      |=> !rst_pin_n ##1 !rst_pin_n;
  endproperty
  a_expiry: assert property (p_expiry) else $error("no reset on counter expiry");

  property p_pulse_len;
    @(posedge pclk) disable iff (!presetn)
    $rose(rst_pin_n) |-> (low_cnt_q == PULSE_N);
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("reset pulse length wrong");

  property p_pulse_max;
    @(posedge pclk) disable iff (!presetn)
    !rst_pin_n |-> (low_cnt_q < PULSE_N);
  endproperty
  a_pulse_max: assert property (p_pulse_max) else $error("reset pulse too long");

  property p_window;
    @(posedge pclk) disable iff (!presetn)
    (wr_ctrl & active & (cnt_q > win_q) & (state_q == wwd_pkg::WWD_IDLE)) |=> !rst_pin_n;
  endproperty
  a_window: assert property (p_window) else $error("no reset on early refresh");

  property p_sticky;
    @(posedge pclk) disable iff (!presetn)
    act_q |=> act_q;
  endproperty
  a_sticky: assert property (p_sticky) else $error("activation cleared without reset");

  property p_inactive;
    @(posedge pclk) disable iff (!presetn)
    (~active & ~(wr_ctrl & pwdata[7]) & (state_q == wwd_pkg::WWD_IDLE)) |=> rst_pin_n;
  endproperty
  a_inactive: assert property (p_inactive) else $error("reset cause while inactive");

  property p_hw;
    @(posedge pclk) disable iff (!presetn)
    (hw_opt_q & wr_ctrl & ~pwdata[7] & ~pwdata[6] & (state_q == wwd_pkg::WWD_IDLE))
      |=> (!rst_pin_n & reset_req);
  endproperty
  a_hw: assert property (p_hw) else $error("hardware option not active");

  property p_sw;
    @(posedge pclk) disable iff (!presetn)
    (wr_ctrl & pwdata[7] & ~pwdata[6] & (state_q == wwd_pkg::WWD_IDLE)) |=> (!rst_pin_n & reset_req);
  endproperty
  a_sw: assert property (p_sw) else $error("software reset missing");

  property p_halt;
    @(posedge pclk) disable iff (!presetn)
    (halt_req & active & halt_opt_q & ~oscillator_irq_enable) |=> (!halt_grant & stat_q[3]);
  endproperty
  a_halt: assert property (p_halt) else $error("halt not turned into reset");

  property p_merge;
    @(posedge pclk) disable iff (!presetn)
    reset_req == !rst_pin_n;
  endproperty
  a_merge: assert property (p_merge) else $error("reset request and pin disagree");

endmodule // wwd_top
`default_nettype wire

//--- verification/test_wwd_top.sv
`timescale 1ns/1ns
`default_nettype none
module test_wwd_top;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        hw_watchdog_opt;
  logic        halt_reset_option;
  logic        oscillator_irq_enable;
  logic        halt_req;
  logic        rst_pin_n;
  logic        reset_req;
  logic        halt_grant;
  int          errors;
  int          compares;
  logic [31:0] d0;
  logic [31:0] d1;
  logic        err;
  int          n;
  int          lows;

  wwd_top #(.PRESCALE(16)) u_dut (
    .pclk                  (pclk),
    .presetn               (presetn),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .hw_watchdog_opt       (hw_watchdog_opt),
    .halt_reset_option     (halt_reset_option),
    .oscillator_irq_enable (oscillator_irq_enable),
    .halt_req              (halt_req),
    .rst_pin_n             (rst_pin_n),
    .reset_req             (reset_req),
    .halt_grant            (halt_grant)
  );

  // Clock of 20 ns period
  always #10 pclk = ~pclk;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Verdict and end of run
  task automatic finish_test();
    if (errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Wait used up
  task automatic timed_out();
    errors++;
    $display("[ERR] %0t wait timed out", $time);
    finish_test();
  endtask

  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                     output logic [31:0] rdata, output logic rerr);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 10);
    if (k >= 10)
      timed_out();
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Register write
  task automatic wr(input logic [11:0] addr, input logic [31:0] wdata);
    logic [31:0] x;
    logic        e;
    apb(1'b1, addr, wdata, x, e);
  endtask

  // Reset pulse: edges until low returned, length checked
  task automatic pulse(output int cnt);
    int m;
    cnt = 0;
    m   = 1;
    while (rst_pin_n !== 1'b0 && cnt < 2000)
    begin
      @(posedge pclk);
      cnt++;
    end
    if (cnt >= 2000)
      timed_out();
    chk(reset_req, 32'h1);
    while (m < 2000)
    begin
      @(posedge pclk);
      if (rst_pin_n !== 1'b0)
        break;
      m++;
    end
    chk(m, 1500);
  endtask

  // One halt request pulse
  task automatic halt();
    @(posedge pclk);
    halt_req <= 1'b1;
    @(posedge pclk);
    halt_req <= 1'b0;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    hw_watchdog_opt = 1'b0;
    halt_reset_option = 1'b0;
    oscillator_irq_enable = 1'b1;
    halt_req = 1'b0;
    errors = 0;
    compares = 0;
    lows = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and unmapped access
    apb(1'b0, wwd_pkg::CTRL_OFS, 32'h0, d0, err);
    chk(d0, 32'h0000007F);
    apb(1'b0, wwd_pkg::WIN_OFS, 32'h0, d0, err);
    chk(d0, 32'h0000007F);
    apb(1'b0, 12'h00C, 32'h0, d0, err);
    chk({d0[30:0], err}, 32'h1);
    // Inactive counter keeps running, never resets
    apb(1'b0, wwd_pkg::CTRL_OFS, 32'h0, d0, err);
    repeat (156) @(posedge pclk);
    apb(1'b0, wwd_pkg::CTRL_OFS, 32'h0, d1, err);
    chk(d0 - d1, 32'hA);
    repeat (1100)
    begin
      @(posedge pclk);
      if (rst_pin_n !== 1'b1)
        lows++;
    end
    chk(lows, 0);
    apb(1'b0, wwd_pkg::STAT_OFS, 32'h0, d0, err);
    chk(d0, 32'h0);
    // Activation is sticky
    wr(wwd_pkg::CTRL_OFS, 32'hFF);
    wr(wwd_pkg::CTRL_OFS, 32'h7F);
    apb(1'b0, wwd_pkg::CTRL_OFS, 32'h0, d0, err);
    chk(d0[7], 32'h1);
    // Refresh inside the window: no reset
    repeat (40) @(posedge pclk);
    wr(wwd_pkg::CTRL_OFS, 32'hFE);
    repeat (20)
    begin
      @(posedge pclk);
      if (rst_pin_n !== 1'b1)
        lows++;
    end
    chk(lows, 0);
    apb(1'b0, wwd_pkg::STAT_OFS, 32'h0, d0, err);
    chk(d0, 32'h0);
    // Refresh above the window limit
    wr(wwd_pkg::WIN_OFS, 32'h50);
    wr(wwd_pkg::CTRL_OFS, 32'hFF);
    pulse(n);
    chk(n, 1);
    apb(1'b0, wwd_pkg::STAT_OFS, 32'h0, d0, err);
    chk(d0[1], 32'h1);
    wr(wwd_pkg::WIN_OFS, 32'h7F);
    // Expiry after k plus one prescaled steps
    for (int k = 0; k < 6; k += 5)
    begin
      wr(wwd_pkg::STAT_OFS, 32'hF);
      wr(wwd_pkg::CTRL_OFS, 32'hC0 | k);
      pulse(n);
      chk(n >= 16 * k + 2 && n <= 16 * k + 17, 32'h1);
      apb(1'b0, wwd_pkg::STAT_OFS, 32'h0, d0, err);
      chk(d0, 32'h1);
    end
    // Software triggered reset
    wr(wwd_pkg::STAT_OFS, 32'hF);
    wr(wwd_pkg::CTRL_OFS, 32'h3F);
    pulse(n);
    chk(n, 1);
    apb(1'b0, wwd_pkg::STAT_OFS, 32'h0, d0, err);
    chk(d0, 32'h4);
    // Halt: granted unless reset option with oscillator irq off
    wr(wwd_pkg::CTRL_OFS, 32'hFF);
    halt_reset_option <= 1'b1;
    halt();
    @(posedge pclk);
    chk({halt_grant, rst_pin_n}, 32'h3);
    halt_reset_option <= 1'b0;
    oscillator_irq_enable <= 1'b0;
    halt();
    @(posedge pclk);
    chk({halt_grant, rst_pin_n}, 32'h3);
    halt_reset_option <= 1'b1;
    halt();
    pulse(n);
    chk(n, 1);
    apb(1'b0, wwd_pkg::STAT_OFS, 32'h0, d0, err);
    chk(d0[3], 32'h1);
    // Hardware option: active without the bit
    hw_watchdog_opt <= 1'b1;
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1'b0, wwd_pkg::CTRL_OFS, 32'h0, d0, err);
    chk(d0[7], 32'h1);
    wr(wwd_pkg::CTRL_OFS, 32'h3F);
    pulse(n);
    chk(n, 1);
    finish_test();
  end
endmodule // test_wwd_top
`default_nettype wire
